// [hw/fwp_defs.vh]
`ifndef FWP_DEFS_VH
`define FWP_DEFS_VH
// command opcodes
`define FWP_OP_WRITE_ENABLE_COMMAND      8'h06
`define FWP_OP_WRDI      8'h04
`define FWP_OP_RDSR      8'h05
`define FWP_OP_RDCR      8'h35
`define FWP_OP_WRSR      8'h01
`define FWP_OP_WRCR      8'h11
`define FWP_OP_PP        8'h02
`define FWP_OP_PE        8'h81
`define FWP_OP_SE        8'h20
`define FWP_OP_BE32      8'h52
`define FWP_OP_BE64      8'hd8
`define FWP_OP_CE        8'hc7
`define FWP_OP_CE_ALT    8'h60
`define FWP_OP_DP        8'hb9
`define FWP_OP_RDP       8'hab
`define FWP_OP_SUS       8'h75
`define FWP_OP_RES       8'h7a
// status bit positions
`define FWP_SR_WIP       0
`define FWP_SR_WEL       1
`define FWP_SR_BP_LO     2
`define FWP_SR_BP_HI     6
`define FWP_SR_SRP0      7
// configuration bit positions
`define FWP_CR_SRP1      0
`define FWP_CR_DRIVE_STRENGTH_BIT1      6
// delivery values
`define FWP_SR_RESET     8'h00
`define FWP_CR_RESET     8'h40
// protection-field masks for status and configuration writes
`define FWP_SR_WP_MASK   8'hfc
`define FWP_CR_WP_MASK   8'h01
// frame lengths in bytes
`define FWP_LEN_CMD      9'h001
`define FWP_LEN_REG      9'h002
`define FWP_LEN_ERASE    9'h004
`define FWP_LEN_PP_MIN   9'h005
`define FWP_LEN_SAT      9'h1ff
// address-range masks (22-bit array)
`define FWP_ADDR_TOP     22'h3fffff
`define FWP_MASK_PAGE    22'h0000ff
`define FWP_MASK_4K      22'h000fff
`define FWP_MASK_32K     22'h007fff
`define FWP_MASK_64K     22'h00ffff
// timing, microseconds and clock rate
`define FWP_CLK_MHZ      25
`define FWP_T_PP_MAX_US  3000
`define FWP_T_ER_MAX_US  20000
`define FWP_T_SUSP_US    30
`endif

// [hw/fwp_range.v]
`timescale 1ns/1ps
`include "fwp_defs.vh"
// decodes the block-protect field and checks a target region against it
module fwp_range
(
  input  wire [4:0]  bp,
  input  wire [21:0] tgt_lo,
  input  wire [21:0] tgt_hi,
  output reg         hit
);
  reg [2:0]  sh;
  reg [21:0] mask;
  reg [21:0] plo;
  reg [21:0] phi;

  // protected window from the field, then overlap with the target
  always @*
  begin
    sh   = 3'h0;
    mask = 22'h000000;
    plo  = 22'h000000;
    phi  = 22'h000000;
    hit  = 1'b0;
    if (bp[4])
    begin
      sh   = (bp[2:0] > 3'h4) ? 3'h3 : (bp[2:0] - 3'h1);
      mask = ((`FWP_MASK_4K + 22'h000001) << sh) - 22'h000001;
    end
    else
    begin
      sh   = bp[2:0] - 3'h1;
      mask = ((`FWP_MASK_64K + 22'h000001) << sh) - 22'h000001;
    end
    if (bp[3])
    begin
      plo = 22'h000000;
      phi = mask;
    end
    else
    begin
      plo = `FWP_ADDR_TOP - mask;
      phi = `FWP_ADDR_TOP;
    end
    if (bp[2:0] == 3'h0)
      hit = 1'b0;
    else if (bp[2:0] == 3'h7)
      hit = 1'b1;
    else
      hit = (tgt_lo <= phi) && (tgt_hi >= plo);
  end
endmodule

// [hw/fwp_top.v]
`timescale 1ns/1ps
`include "fwp_defs.vh"
module fwp_top
#(
  parameter PROG_CYC  = `FWP_T_PP_MAX_US * `FWP_CLK_MHZ,
  parameter ERASE_CYC = `FWP_T_ER_MAX_US * `FWP_CLK_MHZ,
  parameter TMR_W     = 20
)
(
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire        sclk,
  input  wire        cs_n,
  input  wire        si,
  input  wire        wp_n,
  output reg         so_q,
  output reg         so_oe_n_q,
  output reg  [7:0]  status_q,
  output reg  [7:0]  config_q,
  output reg         suspended_q,
  output reg         dpd_q,
  output reg         pp_data_vld_q,
  output reg  [7:0]  pp_data_q,
  output reg         mem_commit_q,
  output reg  [7:0]  mem_op_q,
  output reg  [21:0] mem_addr_q,
  output reg         mem_done_q
);
  localparam ST_STBY = 2'h0;
  localparam ST_BUSY = 2'h1;
  localparam ST_SUSP = 2'h2;
  localparam ST_DPD  = 2'h3;
  localparam [TMR_W-1:0] PROG_T  = PROG_CYC[TMR_W-1:0];
  localparam [TMR_W-1:0] ERASE_T = ERASE_CYC[TMR_W-1:0];

  reg [2:0]       sclk_s;
  reg [2:0]       cs_s;
  reg [1:0]       si_s;
  reg [1:0]       wp_s;
  reg [1:0]       st_q;
  reg [1:0]       st_d;
  reg [2:0]       bit_q;
  reg [8:0]       byte_q;
  reg [7:0]       sh_q;
  reg [7:0]       op_q;
  reg [23:0]      addr_q;
  reg [7:0]       wbyte_q;
  reg [7:0]       out_q;
  reg             rd_q;
  reg [TMR_W-1:0] tmr_q;
  reg [7:0]       sh_n;
  reg [21:0]      tlo;
  reg [21:0]      thi;
  reg             is_mem;
  reg             len_ok;
  wire            hit;

  wire sclk_rise = sclk_s[1] & ~sclk_s[2];
  wire sclk_fall = ~sclk_s[1] & sclk_s[2];
  wire cs_rise   = cs_s[1] & ~cs_s[2];
  wire cs_act    = ~cs_s[1];
  wire write_enable_latch       = status_q[`FWP_SR_WEL];
  wire wp_low    = ~wp_s[1];

  // two-flop synchronisers, third sclk/cs stage for edge finding
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_s <= 3'h0;
      cs_s   <= 3'h7;
      si_s   <= 2'h0;
      wp_s   <= 2'h3;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], sclk};
      cs_s   <= {cs_s[1:0], cs_n};
      si_s   <= {si_s[0], si};
      wp_s   <= {wp_s[0], wp_n};
    end
  end

  // target region of the captured command and its length check
  always @*
  begin
    sh_n   = {sh_q[6:0], si_s[1]};
    tlo    = addr_q[21:0];
    thi    = addr_q[21:0];
    is_mem = 1'b1;
    len_ok = 1'b0;
    case (op_q)
      `FWP_OP_PP:
      begin
        tlo    = addr_q[21:0] & ~`FWP_MASK_PAGE;
        thi    = addr_q[21:0] | `FWP_MASK_PAGE;
        len_ok = byte_q >= `FWP_LEN_PP_MIN;
      end
      `FWP_OP_PE:
      begin
        tlo    = addr_q[21:0] & ~`FWP_MASK_PAGE;
        thi    = addr_q[21:0] | `FWP_MASK_PAGE;
        len_ok = byte_q == `FWP_LEN_ERASE;
      end
      `FWP_OP_SE:
      begin
        tlo    = addr_q[21:0] & ~`FWP_MASK_4K;
        thi    = addr_q[21:0] | `FWP_MASK_4K;
        len_ok = byte_q == `FWP_LEN_ERASE;
      end
      `FWP_OP_BE32:
      begin
        tlo    = addr_q[21:0] & ~`FWP_MASK_32K;
        thi    = addr_q[21:0] | `FWP_MASK_32K;
        len_ok = byte_q == `FWP_LEN_ERASE;
      end
      `FWP_OP_BE64:
      begin
        tlo    = addr_q[21:0] & ~`FWP_MASK_64K;
        thi    = addr_q[21:0] | `FWP_MASK_64K;
        len_ok = byte_q == `FWP_LEN_ERASE;
      end
      `FWP_OP_CE, `FWP_OP_CE_ALT:
      begin
        tlo    = 22'h000000;
        thi    = `FWP_ADDR_TOP;
        len_ok = byte_q == `FWP_LEN_CMD;
      end
      `FWP_OP_WRSR, `FWP_OP_WRCR:
      begin
        is_mem = 1'b0;
        len_ok = byte_q == `FWP_LEN_REG;
      end
      default:
      begin
        is_mem = 1'b0;
        len_ok = byte_q == `FWP_LEN_CMD;
      end
    endcase
    len_ok = len_ok & (bit_q == 3'h0);
  end

  fwp_range i_fwp_range
  (
    .bp     (status_q[`FWP_SR_BP_HI:`FWP_SR_BP_LO]),
    .tgt_lo (tlo),
    .tgt_hi (thi),
    .hit    (hit)
  );

  // serial frame capture, sampled on sclk rising edges
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bit_q         <= 3'h0;
      byte_q        <= 9'h000;
      sh_q          <= 8'h00;
      op_q          <= 8'h00;
      addr_q        <= 24'h000000;
      wbyte_q       <= 8'h00;
      pp_data_vld_q <= 1'b0;
      pp_data_q     <= 8'h00;
    end
    else
    begin
      pp_data_vld_q <= 1'b0;
      if (!cs_act)
      begin
        bit_q  <= 3'h0;
        byte_q <= 9'h000;
      end
      else if (sclk_rise)
      begin
        sh_q  <= sh_n;
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7)
        begin
          if (byte_q != `FWP_LEN_SAT)
            byte_q <= byte_q + 9'h001;
          if (byte_q == 9'h000)
            op_q <= sh_n;
          else if (byte_q < `FWP_LEN_ERASE)
            addr_q <= {addr_q[15:0], sh_n};
          if (byte_q == `FWP_LEN_CMD)
            wbyte_q <= sh_n;
          if ((op_q == `FWP_OP_PP) && (byte_q >= `FWP_LEN_ERASE) && (st_q == ST_STBY))
          begin
            pp_data_vld_q <= 1'b1; // staged only, applied on commit
            pp_data_q     <= sh_n;
          end
        end
      end
    end
  end

  // status and configuration read-out, shifted on sclk falling edges
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_q     <= 8'h00;
      rd_q      <= 1'b0;
      so_q      <= 1'b0;
      so_oe_n_q <= 1'b1;
    end
    else if (!cs_act)
    begin
      rd_q      <= 1'b0;
      so_oe_n_q <= 1'b1;
    end
    else if (sclk_rise && (bit_q == 3'h7) && (byte_q == 9'h000) && (st_q != ST_DPD))
    begin
      if (sh_n == `FWP_OP_RDSR)
      begin
        out_q <= status_q;
        rd_q  <= 1'b1;
      end
      else if (sh_n == `FWP_OP_RDCR)
      begin
        out_q <= config_q;
        rd_q  <= 1'b1;
      end
    end
    else if (sclk_fall && rd_q)
    begin
      so_q      <= out_q[7];
      so_oe_n_q <= 1'b0;
      out_q     <= {out_q[6:0], out_q[7]};
    end
  end

  // control state machine next state
  always @*
  begin
    st_d = st_q;
    case (st_q)
      ST_STBY:
        if (cs_rise && len_ok)
        begin
          if (op_q == `FWP_OP_DP)
            st_d = ST_DPD;
          else if (is_mem && write_enable_latch && !hit)
            st_d = ST_BUSY;
        end
      ST_BUSY:
        if (cs_rise && len_ok && (op_q == `FWP_OP_SUS))
          st_d = ST_SUSP;
        else if (tmr_q == {TMR_W{1'b0}})
          st_d = ST_STBY;
      ST_SUSP:
        if (cs_rise && len_ok && (op_q == `FWP_OP_RES))
          st_d = ST_BUSY;
      ST_DPD:
        if (cs_rise && len_ok && (op_q == `FWP_OP_RDP))
          st_d = ST_STBY;
      default:
        st_d = ST_STBY;
    endcase
  end

  // state, registers, timer and array commit
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q         <= ST_STBY;
      status_q     <= `FWP_SR_RESET;
      config_q     <= `FWP_CR_RESET;
      tmr_q        <= {TMR_W{1'b0}};
      suspended_q  <= 1'b0;
      dpd_q        <= 1'b0;
      mem_commit_q <= 1'b0;
      mem_op_q     <= 8'h00;
      mem_addr_q   <= 22'h000000;
      mem_done_q   <= 1'b0;
    end
    else
    begin
      st_q         <= st_d;
      mem_commit_q <= 1'b0;
      mem_done_q   <= 1'b0;
      suspended_q  <= (st_d == ST_SUSP);
      dpd_q        <= (st_d == ST_DPD);
      status_q[`FWP_SR_WIP] <= (st_d == ST_BUSY);
      if ((st_q == ST_BUSY) && (st_d == ST_BUSY) && (tmr_q != {TMR_W{1'b0}}))
        tmr_q <= tmr_q - {{(TMR_W-1){1'b0}}, 1'b1};
      if ((st_q == ST_BUSY) && (st_d == ST_STBY))
        mem_done_q <= 1'b1;
      if ((st_q == ST_STBY) && cs_rise && len_ok)
      begin
        case (op_q)
          `FWP_OP_WRITE_ENABLE_COMMAND:
            status_q[`FWP_SR_WEL] <= 1'b1;
          `FWP_OP_WRDI:
            status_q[`FWP_SR_WEL] <= 1'b0;
          `FWP_OP_WRSR:
            if (write_enable_latch)
            begin
              if (!wp_low)
                status_q[`FWP_SR_SRP0:`FWP_SR_BP_LO] <= wbyte_q[`FWP_SR_SRP0:`FWP_SR_BP_LO];
              status_q[`FWP_SR_WEL] <= 1'b0;
            end
          `FWP_OP_WRCR:
            if (write_enable_latch)
            begin
              config_q <= wp_low ? ((wbyte_q & ~`FWP_CR_WP_MASK) | (config_q & `FWP_CR_WP_MASK))
                                 : wbyte_q;
              status_q[`FWP_SR_WEL] <= 1'b0;
            end
          default:
            if (is_mem && write_enable_latch && !hit)
            begin
              mem_commit_q          <= 1'b1;
              mem_op_q              <= op_q;
              mem_addr_q            <= tlo;
              status_q[`FWP_SR_WEL] <= 1'b0;
              tmr_q                 <= (op_q == `FWP_OP_PP) ? PROG_T : ERASE_T;
            end
        endcase
      end
    end
  end
endmodule

// [tb/fwp_checker.sv]
`timescale 1ns/1ps
module fwp_checker
#(
  parameter ERASE_CYC = 100
)
(
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       cs_n,
  input wire logic       wp_n,
  input wire logic [7:0] status_q,
  input wire logic [7:0] config_q,
  input wire logic       suspended_q,
  input wire logic       dpd_q,
  input wire logic       mem_commit_q,
  input wire logic       mem_done_q
);
  logic [19:0] busy_cnt_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // length of the current busy stretch
  always @(posedge sys_clk or negedge nrst)
    if (!nrst)
      busy_cnt_q <= 20'h00000;
    else
      busy_cnt_q <= status_q[0] ? busy_cnt_q + 20'h00001 : 20'h00000;
  // commit raises busy and drops the latch together
  commit_busy_a: assert property (mem_commit_q |-> status_q[0] && !status_q[1])
    else $error("commit without busy");
  commit_wel_a: assert property (mem_commit_q |-> $past(status_q[1]))
    else $error("commit without latch");
  busy_bound_a: assert property (busy_cnt_q <= ERASE_CYC + 2)
    else $error("busy too long");
  done_idle_a: assert property (mem_done_q |-> !status_q[0] && $past(status_q[0]))
    else $error("done without busy end");
  wp_hold_a: assert property (!wp_n [*4] |=> $stable(status_q[7:2]) && $stable(config_q[0]))
    else $error("protect bits moved");
  dpd_quiet_a: assert property (dpd_q |=> $stable(status_q) && !mem_commit_q)
    else $error("activity in power-down");
  one_commit_a: assert property (mem_commit_q |=> !mem_commit_q)
    else $error("long commit");
  busy_commit_a: assert property (status_q[0] && $past(status_q[0]) |-> !mem_commit_q)
    else $error("commit while busy");
  commit_cs_a: assert property (mem_commit_q |-> cs_n)
    else $error("commit inside frame");
  susp_idle_a: assert property (suspended_q |-> !status_q[0])
    else $error("busy while suspended");
  // main scenarios reached
  commit_c: cover property (mem_commit_q);
  done_c: cover property (mem_done_q);
  susp_c: cover property ($rose(suspended_q));
  dpd_c: cover property ($rose(dpd_q));
endmodule
bind fwp_top fwp_checker #(.ERASE_CYC(ERASE_CYC)) i_fwp_checker
(
  .sys_clk(sys_clk), .nrst(nrst), .cs_n(cs_n), .wp_n(wp_n), .status_q(status_q), .config_q(config_q),
  .suspended_q(suspended_q), .dpd_q(dpd_q), .mem_commit_q(mem_commit_q), .mem_done_q(mem_done_q)
);

// [tb/fwp_host.sv]
`timescale 1ns/1ps
module fwp_host
(
  input  wire logic sys_clk,
  input  wire logic so,
  input  wire logic so_oe_n,
  output logic      sclk,
  output logic      cs_n,
  output logic      si
);
  logic [7:0] rx;
  // deselected with the clock parked low
  initial
  begin
    rx = 8'h00;
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // n bits msb first, 320 ns per bit
  task automatic frame(input logic [47:0] d, input int n);
    @(negedge sys_clk);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      si = d[47-i];
      repeat (4) @(negedge sys_clk);
      rx = {rx[6:0], so_oe_n ? 1'b1 : so}; // released line reads high through its pull-up
      sclk = 1'b1;
      repeat (4) @(negedge sys_clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    cs_n = 1'b1;
    si = ~si;
    repeat (8) @(negedge sys_clk);
  endtask
endmodule

// [tb/fwp_top_bench.sv]
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module fwp_top_bench;
  logic        sys_clk;
  logic        nrst;
  logic        wp_n;
  wire         sclk;
  wire         cs_n;
  wire         si;
  wire  [7:0]  status_q;
  wire  [7:0]  config_q;
  wire         suspended_q;
  wire         dpd_q;
  wire         mem_commit_q;
  wire  [21:0] mem_addr_q;
  wire         mem_done_q;
  wire         so_q;
  wire         so_oe_n_q;
  wire         pp_data_vld_q;
  wire  [7:0]  pp_data_q;
  wire  [7:0]  mem_op_q;
  int          failures;
  int          checks;
  int          commits;
  int          dones;
  int          cycles;
  logic [21:0] last_addr;
  int          pp_bytes;
  logic [7:0]  last_pp;
  logic [7:0]  last_op;
  fwp_top #(.PROG_CYC(400), .ERASE_CYC(600)) i_fwp_top
  (
    .sys_clk(sys_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so_q(so_q),
    .so_oe_n_q(so_oe_n_q), .status_q(status_q), .config_q(config_q), .suspended_q(suspended_q),
    .dpd_q(dpd_q), .pp_data_vld_q(pp_data_vld_q), .pp_data_q(pp_data_q), .mem_commit_q(mem_commit_q),
    .mem_op_q(mem_op_q), .mem_addr_q(mem_addr_q), .mem_done_q(mem_done_q)
  );
  fwp_host i_fwp_host
  (
    .sys_clk(sys_clk), .so(so_q), .so_oe_n(so_oe_n_q), .sclk(sclk), .cs_n(cs_n), .si(si)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic frm(input logic [47:0] d, input int n);
    i_fwp_host.frame(d, n);
  endtask
  // write enable ahead of the altering frame
  task automatic wen(input logic [47:0] d, input int n);
    frm(48'h060000000000, 8);
    frm(d, n);
  endtask
  task automatic idle_wait;
    repeat (1000)
      if (status_q[0] === 1'b1)
        @(negedge sys_clk);
    // let the done pulse reach the monitor
    repeat (2) @(negedge sys_clk);
  endtask
  // commit and done watch, plus hang limit
  always @(posedge sys_clk)
  begin
    cycles++;
    if (mem_commit_q === 1'b1)
    begin
      commits++;
      last_addr = mem_addr_q;
      last_op = mem_op_q;
    end
    if (mem_done_q === 1'b1)
      dones++;
    if (pp_data_vld_q === 1'b1)
    begin
      pp_bytes++;
      last_pp = pp_data_q;
    end
    if (cycles > 20000)
    begin
      failures++;
      close_out();
    end
  end
  initial
  begin
    nrst = 1'b0;
    wp_n = 1'b1;
    repeat (20) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (30) @(negedge sys_clk);
    `CHK("status", 8'h00, status_q)
    `CHK("config", 8'h40, config_q)
    frm(48'h350000000000, 16);
    `CHK("rdcr", 8'h40, i_fwp_host.rx)
    frm(48'h060000000000, 7);
    `CHK("short", 8'h00, status_q)
    frm(48'h203ef0000000, 32);
    `CHK("no latch", 0, commits)
    frm(48'h060000000000, 8);
    `CHK("latch", 8'h02, status_q)
    frm(48'h040000000000, 8);
    `CHK("wrdi", 8'h00, status_q)
    wen(48'h010400000000, 16);
    `CHK("upper", 8'h04, status_q)
    wen(48'h203f00000000, 32);
    `CHK("top hit", 0, commits)
    frm(48'h203ef0000000, 32);
    `CHK("erase", 1, commits)
    `CHK("addr", 22'h3ef000, last_addr)
    `CHK("erase op", 8'h20, last_op)
    `CHK("busy", 1'b1, status_q[0])
    idle_wait();
    `CHK("done", 1, dones)
    wen(48'h011c00000000, 16);
    `CHK("all", 8'h1c, status_q)
    wen(48'h200000000000, 32);
    `CHK("all hit", 1, commits)
    wp_n = 1'b0;
    wen(48'h010000000000, 16);
    `CHK("wp", 6'h07, status_q[7:2])
    wen(48'h114100000000, 16);
    `CHK("wp cfg", 8'h40, config_q)
    wp_n = 1'b1;
    wen(48'h016400000000, 16);
    `CHK("low 4k", 8'h64, status_q)
    wen(48'h114100000000, 16);
    `CHK("cfg", 8'h41, config_q)
    wen(48'h200000000000, 32);
    frm(48'h02001100a500, 40);
    `CHK("pp", 2, commits)
    `CHK("pp op", 8'h02, last_op)
    `CHK("pp data", 8'ha5, last_pp)
    `CHK("pp bytes", 1, pp_bytes)
    frm(48'h050000000000, 16);
    `CHK("rdsr busy", 8'h65, i_fwp_host.rx)
    `CHK("so released", 1'b1, so_oe_n_q)
    frm(48'h750000000000, 8);
    `CHK("susp", 1'b1, suspended_q)
    frm(48'h7a0000000000, 8);
    repeat (8) @(negedge sys_clk);
    frm(48'h750000000000, 8);
    `CHK("susp again", 1'b1, suspended_q)
    frm(48'h7a0000000000, 8);
    idle_wait();
    `CHK("pp done", 2, dones)
    frm(48'hb90000000000, 8);
    `CHK("dpd", 1'b1, dpd_q)
    wen(48'h201000000000, 32);
    `CHK("dpd hold", 2, commits)
    frm(48'hab0000000000, 8);
    `CHK("wake", 1'b0, dpd_q)
    wen(48'hc70000000000, 8);
    `CHK("chip hit", 2, commits)
    `CHK("chip latch", 8'h66, status_q)
    close_out();
  end
endmodule
